// ===== tgc_pkg.sv
package tgc_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [3:0] TGC_ADDR_GATE_CONTROL = 4'h0;
    localparam logic [3:0] TGC_ADDR_RUN_CONTROL  = 4'h4;
    localparam int         TGC_ADDR_W            = 4;

    // ------------------------------------------------------------------
    // Gate control field positions
    // ------------------------------------------------------------------
    localparam int TGC_BIT_ENABLE   = 7;
    localparam int TGC_BIT_POLARITY = 6;
    localparam int TGC_BIT_TOGGLE   = 5;
    localparam int TGC_BIT_SPULSE   = 4;
    localparam int TGC_BIT_GO_DONE  = 3;
    localparam int TGC_BIT_LEVEL    = 2;
    localparam int TGC_BIT_SEL_HI   = 1;
    localparam int TGC_BIT_SEL_LO   = 0;

    // Run control: counter on bit
    localparam int TGC_BIT_ON       = 0;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [1:0] TGC_SEL_PIN    = 2'h0;
    localparam logic [1:0] TGC_SEL_OVF    = 2'h1;
    localparam logic [1:0] TGC_SEL_CMP_A  = 2'h2;
    localparam logic [1:0] TGC_SEL_CMP_B  = 2'h3;
    localparam logic [1:0] TGC_RESP_OKAY  = 2'h0;
    localparam logic [1:0] TGC_RESP_SLVERR = 2'h2;
    localparam logic [31:0] TGC_ZERO_WORD = 32'h0000_0000;

endpackage

// ===== tgc_gate.sv
// Contract
// - A two-bit gate source select field sits in bits 1-0 of gate_control.
// - Select 00 takes the gate from the external gate pin.
// - Select 01 takes the gate from the 8-bit timer overflow.
// - Select 10 takes the gate from the synced first comparator output.
// - Select 11 takes the gate from the synced second comparator output.
// - A read-only gate level bit shows the gate, regardless of gate enable.
// - Unimplemented register bits and locations read as zero.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
module tgc_gate
    import tgc_pkg::*;
(
    // Clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_resetn,
    // Gate sources
    input  wire logic                  i_gate_pin,
    input  wire logic                  i_timer8_ovf,
    input  wire logic                  i_cmp_a_synced_out,
    input  wire logic                  i_cmp_b_synced_out,
    // Counter interface
    output logic                       o_count_enable,
    output logic                       o_counter_on,
    // AXI4-Lite write address
    input  wire logic [TGC_ADDR_W-1:0] i_awaddr,
    input  wire logic                  i_awvalid,
    output logic                       o_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]           i_wdata,
    input  wire logic [3:0]            i_wstrb,
    input  wire logic                  i_wvalid,
    output logic                       o_wready,
    // AXI4-Lite write response
    output logic [1:0]                 o_bresp,
    output logic                       o_bvalid,
    input  wire logic                  i_bready,
    // AXI4-Lite read address
    input  wire logic [TGC_ADDR_W-1:0] i_araddr,
    input  wire logic                  i_arvalid,
    output logic                       o_arready,
    // AXI4-Lite read data
    output logic [31:0]                o_rdata,
    output logic [1:0]                 o_rresp,
    output logic                       o_rvalid,
    input  wire logic                  i_rready
);

    // ------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------
    logic       gate_enable;
    logic       gate_polarity;
    logic       gate_toggle_mode;
    logic       gate_single_pulse_mode;
    logic       single_pulse_go_done;
    logic [1:0] gate_source_select;
    logic       counter_on;
    logic       gate_level;
    // Gate path state
    logic       toggle_ff;
    logic       prev_gate;
    logic       pulse_active;

    // Write channel holding
    logic                  aw_held;
    logic                  w_held;
    logic [TGC_ADDR_W-1:0] aw_addr;
    logic [31:0]           w_data;
    logic                  w_lane0;
    logic                  do_write;

    // ------------------------------------------------------------------
    // Gate source selection
    // ------------------------------------------------------------------
    function automatic logic pick_source(input logic [1:0] sel,
                                         input logic       pin,
                                         input logic       ovf,
                                         input logic       ca,
                                         input logic       cb);
        logic r;
        r = pin;
        unique case (sel)
            TGC_SEL_PIN:   r = pin;
            TGC_SEL_OVF:   r = ovf;
            TGC_SEL_CMP_A: r = ca;
            TGC_SEL_CMP_B: r = cb;
        endcase
        return r;
    endfunction

    // Combinational gate path, shared by level, toggle and pulse
    logic raw_gate;
    logic pol_gate;
    logic next_gate_level;

    // Polarity applied first so toggle and pulse work on active edges
    always_comb begin
        raw_gate = pick_source(gate_source_select, i_gate_pin, i_timer8_ovf,
                               i_cmp_a_synced_out, i_cmp_b_synced_out);
        pol_gate = gate_polarity ? raw_gate : ~raw_gate;
        if (gate_single_pulse_mode) begin
            next_gate_level = pulse_active &
                (gate_toggle_mode ? toggle_ff : pol_gate);
        end else if (gate_toggle_mode) begin
            next_gate_level = toggle_ff;
        end else begin
            next_gate_level = pol_gate;
        end
    end

    // Toggle flip-flop, cleared when mode off or counter stopped
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            toggle_ff <= 1'b0;
            prev_gate <= 1'b0;
        end else begin
            // Edge taken after polarity, so toggling follows the active edge
            prev_gate <= pol_gate;
            if (!gate_toggle_mode || !counter_on) begin
                toggle_ff <= 1'b0;
            end else if (pol_gate && !prev_gate) begin
                toggle_ff <= ~toggle_ff;
            end
        end
    end

    // gate level tracks gate, not gated by enable
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            gate_level <= 1'b0;
        end else begin
            gate_level <= next_gate_level;
        end
    end

    // Single pulse: armed by go, one active window, then done
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            pulse_active <= 1'b0;
        end else if (!gate_single_pulse_mode || !single_pulse_go_done) begin
            pulse_active <= 1'b0;
        end else if (gate_toggle_mode ? toggle_ff : pol_gate) begin
            pulse_active <= 1'b1;
        end
    end

    // counting qualified by on, enable and gate
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_count_enable <= 1'b0;
            o_counter_on   <= 1'b0;
        end else begin
            o_counter_on   <= counter_on;
            // Registered, so the counter sees a clean enable a cycle late
            o_count_enable <= counter_on & (~gate_enable | next_gate_level);
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    // Address and data accepted in either order, response after both
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr   <= '0;
            w_data    <= TGC_ZERO_WORD;
            w_lane0   <= 1'b0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_held   <= 1'b1;
                aw_addr   <= i_awaddr;
                o_awready <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_held   <= 1'b1;
                w_data   <= i_wdata;
                // Only the low lane carries register bits
                w_lane0  <= i_wstrb[0];
                o_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
            end
            // Readies return only after the response is taken
            if (o_bvalid && i_bready) begin
                o_awready <= 1'b1;
                o_wready  <= 1'b1;
            end
        end
    end

    // Commit once both halves are held; a pending response blocks it
    assign do_write = aw_held & w_held & ~o_bvalid;

    // Write response, unmapped address answers SLVERR
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_bvalid <= 1'b0;
            o_bresp  <= TGC_RESP_OKAY;
        end else if (do_write) begin
            o_bvalid <= 1'b1;
            o_bresp  <= (aw_addr == TGC_ADDR_GATE_CONTROL ||
                         aw_addr == TGC_ADDR_RUN_CONTROL)
                        ? TGC_RESP_OKAY : TGC_RESP_SLVERR;
        end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // Writable fields; go/done cleared by hardware at end of pulse
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            gate_enable            <= 1'b0;
            gate_polarity          <= 1'b0;
            gate_toggle_mode       <= 1'b0;
            gate_single_pulse_mode <= 1'b0;
            single_pulse_go_done   <= 1'b0;
            gate_source_select     <= TGC_SEL_PIN;
            counter_on             <= 1'b0;
        end else begin
            // Window closed: go/done drops by itself
            if (pulse_active && !next_gate_level) begin
                single_pulse_go_done <= 1'b0;
            end
            if (do_write && w_lane0) begin
                if (aw_addr == TGC_ADDR_GATE_CONTROL) begin
                    gate_enable      <= w_data[TGC_BIT_ENABLE];
                    gate_polarity    <= w_data[TGC_BIT_POLARITY];
                    gate_toggle_mode <= w_data[TGC_BIT_TOGGLE];
                    gate_single_pulse_mode <= w_data[TGC_BIT_SPULSE];
                    // Go only armed in pulse mode; hardware clear wins
                    if (w_data[TGC_BIT_GO_DONE] &&
                        w_data[TGC_BIT_SPULSE] &&
                        !(pulse_active && !next_gate_level)) begin
                        single_pulse_go_done <= 1'b1;
                    end else if (!w_data[TGC_BIT_GO_DONE]) begin
                        single_pulse_go_done <= 1'b0;
                    end
                    gate_source_select <=
                        w_data[TGC_BIT_SEL_HI:TGC_BIT_SEL_LO];
                end else if (aw_addr == TGC_ADDR_RUN_CONTROL) begin
                    // Run control holds only the on bit
                    counter_on <= w_data[TGC_BIT_ON];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    // Read word built from the live address at the handshake
    logic [31:0] rd_word;
    logic        rd_ok;

    // unused bits and addresses read zero
    always_comb begin
        rd_word = TGC_ZERO_WORD;
        rd_ok   = 1'b1;
        if (i_araddr == TGC_ADDR_GATE_CONTROL) begin
            rd_word[TGC_BIT_ENABLE]   = gate_enable;
            rd_word[TGC_BIT_POLARITY] = gate_polarity;
            rd_word[TGC_BIT_TOGGLE]   = gate_toggle_mode;
            rd_word[TGC_BIT_SPULSE]   = gate_single_pulse_mode;
            rd_word[TGC_BIT_GO_DONE]  = single_pulse_go_done;
            rd_word[TGC_BIT_LEVEL]    = gate_level;
            rd_word[TGC_BIT_SEL_HI:TGC_BIT_SEL_LO] = gate_source_select;
        end else if (i_araddr == TGC_ADDR_RUN_CONTROL) begin
            rd_word[TGC_BIT_ON] = counter_on;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // One read at a time; arready drops until data taken
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= TGC_ZERO_WORD;
            o_rresp   <= TGC_RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            // Captured once; stays put while rvalid waits for rready
            o_rdata   <= rd_word;
            o_rresp   <= rd_ok ? TGC_RESP_OKAY : TGC_RESP_SLVERR;
        end else if (o_rvalid && i_rready) begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
        end
    end

endmodule

// ===== tgc_gate_sva.sv
module tgc_gate_sva
    import tgc_pkg::*;
(
    // Clock, reset, counter
    input wire logic                  i_clk_sys,
    input wire logic                  i_resetn,
    input wire logic                  o_count_enable,
    input wire logic                  o_counter_on,
    // Register bus
    input wire logic                  i_awvalid,
    input wire logic                  o_awready,
    input wire logic                  o_bvalid,
    input wire logic                  i_bready,
    input wire logic [TGC_ADDR_W-1:0] i_araddr,
    input wire logic                  i_arvalid,
    input wire logic                  o_arready,
    input wire logic [31:0]           o_rdata,
    input wire logic [1:0]            o_rresp,
    input wire logic                  o_rvalid,
    input wire logic                  i_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    a_rd_unmapped: assert property (
        i_arvalid && o_arready && i_araddr != TGC_ADDR_GATE_CONTROL
        && i_araddr != TGC_ADDR_RUN_CONTROL
        |=> o_rdata == TGC_ZERO_WORD && o_rresp == TGC_RESP_SLVERR)
        else $error("unmapped read not refused");
    a_rd_upper: assert property (o_rvalid |-> o_rdata[31:8] == 0)
        else $error("unused read bits set");
    a_run_upper: assert property (
        i_arvalid && o_arready && i_araddr == TGC_ADDR_RUN_CONTROL
        |=> o_rdata[31:1] == 0 && o_rresp == TGC_RESP_OKAY)
        else $error("run control read wrong");
    // Enable and the on copy leave their flops at the same edge
    a_gate_off: assert property (!o_counter_on |-> !o_count_enable)
        else $error("counting while off");
    a_rvalid_hold: assert property (o_rvalid && !i_rready
        |=> o_rvalid && $stable(o_rdata)) else $error("read data dropped");
    a_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("write response dropped");
    a_ar_busy: assert property (i_arvalid && o_arready
        |=> o_rvalid && !o_arready) else $error("read answer late");
    a_aw_busy: assert property (i_awvalid && o_awready |=> !o_awready)
        else $error("write address taken twice");

    c_read: cover property (o_rvalid && i_rready);
    c_write: cover property (o_bvalid && i_bready);
    c_count: cover property ($rose(o_count_enable));
endmodule

// ===== tgc_src_model.sv
module tgc_src_model (
    // Clock and wanted levels
    input  wire logic       i_clk_sys,
    input  wire logic [3:0] i_level,
    // Gate sources
    output logic            o_gate_pin,
    output logic            o_timer8_ovf,
    output logic            o_cmp_a,
    output logic            o_cmp_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sources move after the edge, as synchronous outputs would
    always_ff @(posedge i_clk_sys) begin
        {o_cmp_b, o_cmp_a, o_timer8_ovf, o_gate_pin} <= i_level;
    end
endmodule

// ===== timer1_gate_control_tb.sv
module timer1_gate_control_tb
    import tgc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk_sys = 1'h0;
    logic        i_resetn = 1'h0;
    // Pin high at reset so active-low polarity sees an idle gate
    logic [3:0]  lvl = 4'hf;
    logic [3:0]  i_awaddr = 4'h0, i_araddr = 4'h0;
    logic        i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
    logic        i_arvalid = 1'h0, i_rready = 1'h0;
    logic [31:0] i_wdata = 32'h0, rdat;
    logic [1:0]  rsp;
    wire         pin, ovf, ca, cb, o_count_enable, o_counter_on;
    wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    wire  [1:0]  o_bresp, o_rresp;
    wire  [31:0] o_rdata;
    int          fails = 0, checks_done = 0, cycles = 0;

    always #12.5 i_clk_sys = ~i_clk_sys;

    tgc_src_model src (.i_clk_sys(i_clk_sys), .i_level(lvl),
        .o_gate_pin(pin), .o_timer8_ovf(ovf), .o_cmp_a(ca), .o_cmp_b(cb));
    tgc_gate dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_gate_pin(pin), .i_timer8_ovf(ovf), .i_cmp_a_synced_out(ca),
        .i_cmp_b_synced_out(cb), .o_count_enable(o_count_enable),
        .o_counter_on(o_counter_on), .i_awaddr(i_awaddr),
        .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
        .i_wstrb(4'hf), .i_wvalid(i_wvalid), .o_wready(o_wready),
        .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
        .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
        .i_rready(i_rready));

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Both channels offered together, each dropped once taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'h1;
        i_wvalid <= 1'h1;
        i_bready <= 1'h1;
        forever begin
            @(posedge i_clk_sys);
            if (i_awvalid && o_awready)
                i_awvalid <= 1'h0;
            if (i_wvalid && o_wready)
                i_wvalid <= 1'h0;
            if (o_bvalid) begin
                rsp = o_bresp;
                i_bready <= 1'h0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge i_clk_sys);
        i_araddr <= a;
        i_arvalid <= 1'h1;
        i_rready <= 1'h1;
        forever begin
            @(posedge i_clk_sys);
            if (i_arvalid && o_arready)
                i_arvalid <= 1'h0;
            if (o_rvalid) begin
                rdat = o_rdata;
                rsp = o_rresp;
                i_rready <= 1'h0;
                break;
            end
        end
    endtask

    // Set sources and control, then check counting and the read-back
    task automatic step(input logic [7:0] c, input logic [3:0] s,
                        input logic l, input logic ce);
        lvl <= s;
        wr(TGC_ADDR_GATE_CONTROL, {24'h0, c});
        repeat (3) @(posedge i_clk_sys);
        chk("count_enable", {31'h0, ce}, {31'h0, o_count_enable});
        rd(TGC_ADDR_GATE_CONTROL);
        chk("gate_control", {24'h0, c | {5'h0, l, 2'h0}}, rdat);
    endtask

    // Hang guard
    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        repeat (6) @(posedge i_clk_sys);
        i_resetn <= 1'h1;
        rd(TGC_ADDR_GATE_CONTROL);
        chk("reset value", 32'h0, rdat);
        rd(4'h8);
        chk("unmapped rdata", 32'h0, rdat);
        chk("unmapped rresp", {30'h0, TGC_RESP_SLVERR}, {30'h0, rsp});
        wr(4'hc, 32'hffff_ffff);
        chk("unmapped bresp", {30'h0, TGC_RESP_SLVERR}, {30'h0, rsp});
        wr(TGC_ADDR_RUN_CONTROL, 32'hffff_ffff);
        chk("run bresp", {30'h0, TGC_RESP_OKAY}, {30'h0, rsp});
        rd(TGC_ADDR_RUN_CONTROL);
        chk("run_control", 32'h1, rdat);
        chk("counter_on", 32'h1, {31'h0, o_counter_on});
        $display("test register_map done");
        for (int i = 0; i < 4; i++) begin
            step(8'hc0|8'(i), 4'h1<<i, 1'h1, 1'h1);
            step(8'hc0|8'(i), ~(4'h1<<i), 1'h0, 1'h0);
        end
        $display("test source_select done");
        step(8'h40, 4'h1, 1'h1, 1'h1);
        step(8'h40, 4'h0, 1'h0, 1'h1);
        step(8'h80, 4'h0, 1'h1, 1'h1);
        step(8'h80, 4'h1, 1'h0, 1'h0);
        wr(TGC_ADDR_RUN_CONTROL, 32'h0);
        step(8'h80, 4'h0, 1'h1, 1'h0);
        $display("test polarity_and_off done");
        // Toggle: level flips on each active rising edge only
        wr(TGC_ADDR_RUN_CONTROL, 32'h1);
        step(8'he0, 4'h0, 1'h0, 1'h0);
        step(8'he0, 4'h1, 1'h1, 1'h1);
        step(8'he0, 4'h0, 1'h1, 1'h1);
        step(8'he0, 4'h1, 1'h0, 1'h0);
        $display("test toggle done");
        // Single pulse: one window after go, then go/done clears itself
        lvl <= 4'h0;
        wr(TGC_ADDR_GATE_CONTROL, 32'hd8);
        lvl <= 4'h1;
        repeat (4) @(posedge i_clk_sys);
        chk("pulse open", 32'h1, {31'h0, o_count_enable});
        lvl <= 4'h0;
        repeat (4) @(posedge i_clk_sys);
        rd(TGC_ADDR_GATE_CONTROL);
        chk("pulse done", 32'hd0, rdat);
        lvl <= 4'h1;
        repeat (4) @(posedge i_clk_sys);
        chk("pulse once", 32'h0, {31'h0, o_count_enable});
        $display("test single_pulse done");
        final_report();
    end
endmodule

bind tgc_gate tgc_gate_sva u_sva (.i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn), .o_count_enable(o_count_enable),
    .o_counter_on(o_counter_on), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
    .i_rready(i_rready));
